// ### verilog/fcl_fault_cfg.sv
`timescale 1ns/1ps
module fcl_fault_cfg #(
    parameter int MS_CYCLES = fcl_pkg::MS_CYCLES
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // pins, synchronised inside
    input wire logic phase_over_limit,
    input wire logic motor_absent_raw,
    // same-clock inputs from the control core
    input wire logic pwm_cycle_start,
    input wire logic high_side_mod,
    input wire logic [15:0] phase_current_ma,
    input wire logic [7:0] sense_amp_gain,
    // outputs
    output fcl_pkg::fcl_gate_e gate_state,
    output logic fault_output_low,
    output logic absent_motor,
    output logic irq
);
    import fcl_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PCL_RUN = 2'b00,
        PCL_HOLD = 2'b01
    } fcl_pcl_e;

    typedef enum logic [1:0] {
        LCK_OK = 2'b00,
        LCK_LATCHED = 2'b01,
        LCK_RETRY = 2'b10
    } fcl_lck_e;

    fcl_cfg_s cfg_reg;
    logic [IRQ_BITS-1:0] irq_status_reg;
    logic [IRQ_BITS-1:0] irq_enable_reg;
    fcl_pcl_e pcl_reg;
    fcl_pcl_e pcl_next;
    fcl_lck_e lck_reg;
    fcl_lck_e lck_next;
    logic [2:0] retry_left_reg;
    logic [2:0] retry_left_next;
    logic [31:0] ms_div_reg;
    logic ms_tick_reg;
    logic over_sync;
    logic absent_sync;
    logic absent_done;
    logic absent_done_d_reg;
    logic lock_retry_done;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    fcl_sync #(
        .W(2)
    ) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in({phase_over_limit, motor_absent_raw}),
        .sync_out({over_sync, absent_sync})
    );

    // ------------------------------------------------------------
    // ms tick divider
    // ------------------------------------------------------------
    wire ms_wrap = (ms_div_reg == 32'(MS_CYCLES - 1));
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ms_div_reg <= 32'h0;
            ms_tick_reg <= 1'b0;
        end else begin
            ms_div_reg <= ms_wrap ? 32'h0 : ms_div_reg + 32'h1;
            ms_tick_reg <= ms_wrap;
        end
    end

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    wire setup = psel && !penable;
    wire access = psel && penable && pready;
    wire hit_cfg = (paddr == ADDR_CFG);
    wire hit_status = (paddr == ADDR_IRQ_STATUS);
    wire hit_enable = (paddr == ADDR_IRQ_ENABLE);
    wire hit_clear = (paddr == ADDR_IRQ_CLEAR);
    wire hit_state = (paddr == ADDR_STATE);
    wire hit_ctrl = (paddr == ADDR_CTRL);
    wire mapped = hit_cfg | hit_status | hit_enable | hit_clear | hit_state | hit_ctrl;
    wire wr = access && pwrite && mapped;
    wire [31:0] strb_mask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
    wire [31:0] cfg_word = cfg_reg;
    // whole word kept, reserved bits included, so software reads back what it wrote
    wire [31:0] cfg_merged = (cfg_word & ~strb_mask) | (pwdata & strb_mask); // [R10]
    wire clear_hit = wr && hit_clear && pstrb[0];
    wire [IRQ_BITS-1:0] clear_bits = clear_hit ? pwdata[IRQ_BITS-1:0] : '0;
    wire lock_release = wr && hit_ctrl && pstrb[0] && pwdata[CTRL_LOCK_RELEASE];
    fcl_status_s status_now;
    wire [31:0] rd_mux =
        hit_cfg ? cfg_word :
        hit_status ? {{(32 - IRQ_BITS){1'b0}}, irq_status_reg} :
        hit_enable ? {{(32 - IRQ_BITS){1'b0}}, irq_enable_reg} :
        hit_state ? {24'h0, 1'b0, status_now} :
        32'h0;

    // zero-wait slave: pready rises in the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end else begin
            pready <= setup;
            pslverr <= setup && !mapped;
            prdata <= (setup && !pwrite) ? rd_mux : 32'h0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_reg <= CFG_RESET; // [R10]
            irq_enable_reg <= IRQ_RESET;
        end else begin
            if (wr && hit_cfg) begin
                cfg_reg <= cfg_merged; // [R10]
            end
            if (wr && hit_enable && pstrb[0]) begin
                irq_enable_reg <= pwdata[IRQ_BITS-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // per-cycle current limit
    // ------------------------------------------------------------
    wire [3:0] pcl_mode = cfg_reg.per_cycle_limit_reaction;
    wire pcl_next_cycle = (pcl_mode == PCL_NEXT_NF) || (pcl_mode == PCL_NEXT_QUIET); // [R2]
    // sense-release modes are only meaningful with high-side modulation
    wire pcl_sense = ((pcl_mode == PCL_SENSE_NF) || (pcl_mode == PCL_SENSE_QUIET))
        && high_side_mod; // [R3]
    wire pcl_retry = (pcl_mode == PCL_RETRY_NF) || (pcl_mode == PCL_RETRY_QUIET); // [R4]
    wire pcl_acts = pcl_next_cycle || pcl_sense || pcl_retry;
    wire pcl_report = (pcl_mode == PCL_REPORT); // [R5]
    // codes 7 and up, and sense codes without high-side modulation, neither act nor report
    wire pcl_enabled = pcl_acts || pcl_report; // [R6]
    wire pcl_flags_fault = (pcl_mode == PCL_NEXT_NF) || (pcl_mode == PCL_SENSE_NF)
        || (pcl_mode == PCL_RETRY_NF); // [R2] [R3] [R4]
    wire over_rise_ok = over_sync && pcl_enabled && (pcl_reg == PCL_RUN);
    wire [2:0] retry_load = (cfg_reg.per_cycle_retry_count == 3'h0) ? 3'h1
        : cfg_reg.per_cycle_retry_count;

    always_comb begin
        pcl_next = pcl_reg;
        retry_left_next = retry_left_reg;
        unique case (pcl_reg)
            PCL_RUN: begin
                if (over_sync && pcl_acts) begin
                    pcl_next = PCL_HOLD;
                    retry_left_next = retry_load;
                end
            end
            PCL_HOLD: begin
                if (!pcl_acts) begin
                    pcl_next = PCL_RUN;
                end else if (pcl_next_cycle && pwm_cycle_start) begin
                    pcl_next = PCL_RUN; // [R2]
                end else if (pcl_sense && !over_sync) begin
                    pcl_next = PCL_RUN; // [R3]
                end else if (pcl_retry && pwm_cycle_start) begin
                    retry_left_next = retry_left_reg - 3'h1; // [R4]
                    if (retry_left_reg == 3'h1) begin
                        pcl_next = PCL_RUN;
                    end
                end
            end
            default: pcl_next = PCL_RUN;
        endcase
    end

    // ------------------------------------------------------------
    // lock detection
    // ------------------------------------------------------------
    wire [10:0] lock_mv = 11'(cfg_reg.lock_threshold * LOCK_STEP_MV); // [R7]
    // amps = volts / gain, compared as current * gain against volts to avoid a divider
    wire [23:0] sensed_mv = phase_current_ma * sense_amp_gain;
    wire [23:0] limit_mv = {13'h0, lock_mv} * 24'h0003e8;
    wire lock_cond = (cfg_reg.lock_threshold != 4'h0) && (sensed_mv >= limit_mv); // [R7] [R8]
    wire [3:0] lck_mode = cfg_reg.lock_reaction;
    wire lck_latch = (lck_mode <= 4'h3); // [R9]
    wire lck_auto = (lck_mode >= 4'h4) && (lck_mode <= 4'h7); // [R9]
    wire lck_enabled = lck_latch || lck_auto || (lck_mode == LCK_REPORT); // [R9]
    wire lock_event = lock_cond && lck_enabled && (lck_reg == LCK_OK);
    wire [9:0] lock_retry_ms = 10'({7'h0, cfg_reg.lock_retry_time} + 10'h1)
        * LOCK_RETRY_STEP_MS;

    always_comb begin
        lck_next = lck_reg;
        unique case (lck_reg)
            LCK_OK: begin
                if (lock_cond && lck_latch) begin
                    lck_next = LCK_LATCHED; // [R9]
                end else if (lock_cond && lck_auto) begin
                    lck_next = LCK_RETRY; // [R9]
                end
            end
            LCK_LATCHED: begin
                if (lock_release) begin
                    lck_next = LCK_OK;
                end
            end
            LCK_RETRY: begin
                if (lock_retry_done) begin
                    lck_next = LCK_OK;
                end
            end
            default: lck_next = LCK_OK;
        endcase
    end

    fcl_ms_timer u_lock_retry (
        .pclk(pclk),
        .presetn(presetn),
        .ms_tick(ms_tick_reg),
        .run(lck_reg == LCK_RETRY),
        .limit_ms(lock_retry_ms),
        .done(lock_retry_done)
    );

    // ------------------------------------------------------------
    // absent motor filter
    // ------------------------------------------------------------
    fcl_ms_timer u_absent (
        .pclk(pclk),
        .presetn(presetn),
        .ms_tick(ms_tick_reg),
        .run(absent_sync),
        .limit_ms(absent_filter_ms(cfg_reg.absent_motor_filter_time)), // [R1]
        .done(absent_done)
    );
    wire absent_rise = absent_done && !absent_done_d_reg;

    // ------------------------------------------------------------
    // gate request, fault pin, interrupts
    // ------------------------------------------------------------
    wire [1:0] lck_sub = lck_mode[1:0];
    wire lck_holding = (lck_reg != LCK_OK);
    fcl_gate_e gate_next;
    assign gate_next =
        (lck_holding && lck_sub == 2'h0) ? GATE_TRISTATE :
        (lck_holding && lck_sub == 2'h1) ? GATE_RECIRC :
        (lck_holding && lck_sub == 2'h2) ? GATE_HS_BRAKE :
        lck_holding ? GATE_LS_BRAKE :
        (pcl_reg == PCL_HOLD) ? GATE_RECIRC : // [R2] [R3] [R4]
        GATE_DRIVE;
    // of the lock faults only latched ones pull the pin; the lock retry modes recover silently
    wire fault_next = ((pcl_reg == PCL_HOLD) && pcl_flags_fault) || (lck_reg == LCK_LATCHED);
    wire [IRQ_BITS-1:0] irq_set = {absent_rise, lock_event, over_rise_ok};
    // a new event wins over a clear in the same cycle
    wire [IRQ_BITS-1:0] irq_status_next = (irq_status_reg & ~clear_bits) | irq_set;

    assign status_now = '{gate: gate_state, fault_low: fault_output_low,
        lock_held: lck_holding, limit_active: (pcl_reg == PCL_HOLD),
        absent_motor: absent_motor};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pcl_reg <= PCL_RUN;
            lck_reg <= LCK_OK;
            retry_left_reg <= 3'h0;
            absent_done_d_reg <= 1'b0;
            irq_status_reg <= IRQ_RESET;
            gate_state <= GATE_DRIVE;
            fault_output_low <= 1'b1;
            absent_motor <= 1'b0;
            irq <= 1'b0;
        end else begin
            pcl_reg <= pcl_next;
            lck_reg <= lck_next;
            retry_left_reg <= retry_left_next;
            absent_done_d_reg <= absent_done;
            irq_status_reg <= irq_status_next;
            gate_state <= gate_next;
            fault_output_low <= !fault_next;
            absent_motor <= absent_done; // [R1]
            irq <= |(irq_status_next & irq_enable_reg);
        end
    end
endmodule

// ### verilog/fcl_pkg.sv
// Notes on behaviour
// [R1] bits 29:27 pick absent-motor filter time, 1 ms (code 0) to 1000 ms (code 7)
// [R2] reaction codes 0,1: recirculate, resume next pwm cycle; fault only for 0
// [R3] codes 2,3: recirculate until phase sense drops; high-side modulation only; fault for 2
// [R4] codes 4,5: recirculate for retry pwm cycles, then resume; fault for 4
// [R5] code 6: report the over-limit event only, outputs untouched
// [R6] code 7 and above: per-cycle current limiting fully disabled
// [R7] bits 22:19 set lock threshold 0.1 V steps, 0.1 V to 1.5 V; code 0 reserved
// [R8] lock current equals threshold voltage divided by sense amplifier gain
// [R9] bits 18:15 pick lock reaction: latched, retry, report only or disabled
// [R10] config word resets to zero; reserved bit 30 reads back as written
package fcl_pkg;

    // ------------------------------------------------------------
    // register map (byte addresses on apb)
    // ------------------------------------------------------------
    localparam logic [11:0] REG_CFG_INDEX = 12'h092;
    localparam logic [11:0] ADDR_CFG = {REG_CFG_INDEX[9:0], 2'b00};
    localparam logic [11:0] ADDR_IRQ_STATUS = 12'h000;
    localparam logic [11:0] ADDR_IRQ_ENABLE = 12'h004;
    localparam logic [11:0] ADDR_IRQ_CLEAR = 12'h008;
    localparam logic [11:0] ADDR_STATE = 12'h00c;
    localparam logic [11:0] ADDR_CTRL = 12'h010;
    localparam logic [31:0] CFG_RESET = 32'h0000_0000;
    localparam logic [2:0] IRQ_RESET = 3'h0;

    // irq bit positions
    localparam int IRQ_PER_CYCLE = 0;
    localparam int IRQ_LOCK = 1;
    localparam int IRQ_ABSENT = 2;
    localparam int IRQ_BITS = 3;

    // ctrl bit positions
    localparam int CTRL_LOCK_RELEASE = 0;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 25;
    localparam int MS_NS = 1000000;
    localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
    localparam int MS_W = 10;
    localparam logic [10:0] LOCK_STEP_MV = 11'h064;
    localparam logic [9:0] LOCK_RETRY_STEP_MS = 10'h064;

    // ------------------------------------------------------------
    // config word layout
    // ------------------------------------------------------------
    typedef struct packed {
        logic parity;
        logic spare_hi;
        logic [2:0] absent_motor_filter_time;
        logic [3:0] per_cycle_limit_reaction;
        logic [3:0] lock_threshold;
        logic [3:0] lock_reaction;
        logic [3:0] lock_filter_time;
        logic [2:0] per_cycle_retry_count;
        logic spare_lo;
        logic [3:0] motor_lock_mode;
        logic [2:0] lock_retry_time;
    } fcl_cfg_s;

    // gate driver request toward the power stage
    typedef enum logic [2:0] {
        GATE_DRIVE = 3'b000,
        GATE_TRISTATE = 3'b001,
        GATE_RECIRC = 3'b010,
        GATE_HS_BRAKE = 3'b011,
        GATE_LS_BRAKE = 3'b100
    } fcl_gate_e;

    typedef struct packed {
        fcl_gate_e gate;
        logic fault_low;
        logic lock_held;
        logic limit_active;
        logic absent_motor;
    } fcl_status_s;

    localparam logic [3:0] PCL_NEXT_NF = 4'h0;
    localparam logic [3:0] PCL_NEXT_QUIET = 4'h1;
    localparam logic [3:0] PCL_SENSE_NF = 4'h2;
    localparam logic [3:0] PCL_SENSE_QUIET = 4'h3;
    localparam logic [3:0] PCL_RETRY_NF = 4'h4;
    localparam logic [3:0] PCL_RETRY_QUIET = 4'h5;
    localparam logic [3:0] PCL_REPORT = 4'h6;
    localparam logic [3:0] LCK_REPORT = 4'h8;

    function automatic logic [9:0] absent_filter_ms(input logic [2:0] code);
        logic [9:0] ms;
        ms = 10'h001;
        unique case (code)
            3'h0: ms = 10'h001;
            3'h1: ms = 10'h00a;
            3'h2: ms = 10'h019;
            3'h3: ms = 10'h032;
            3'h4: ms = 10'h064;
            3'h5: ms = 10'h0fa;
            3'h6: ms = 10'h1f4;
            3'h7: ms = 10'h3e8;
        endcase
        return ms;
    endfunction

endpackage

// ### verilog/fcl_sync.sv
`timescale 1ns/1ps
module fcl_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // data
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_reg;

    // -----------------------------------------
    // two stages; the first is read only by the second
    // -----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_reg <= '0;
            sync_out <= '0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule

// ### verilog/fcl_ms_timer.sv
`timescale 1ns/1ps
module fcl_ms_timer (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // control
    input wire logic ms_tick,
    input wire logic run,
    input wire logic [fcl_pkg::MS_W-1:0] limit_ms,
    // result
    output logic done
);
    import fcl_pkg::*;

    logic [MS_W-1:0] count_reg;
    wire reached = (count_reg >= limit_ms);

    // -----------------------------------------
    // counts whole ms while run holds; run low restarts
    // -----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_reg <= '0;
            done <= 1'b0;
        end else if (!run) begin
            count_reg <= '0;
            done <= 1'b0;
        end else begin
            if (ms_tick && !reached) begin
                count_reg <= count_reg + 1'b1;
            end
            done <= reached;
        end
    end
endmodule

// ### bench/fcl_fault_cfg_monitor.sv
`timescale 1ns/1ps
module fcl_fault_cfg_monitor #(
    parameter int MS_CYCLES = 10
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // core side
    input wire logic phase_over_limit,
    input wire logic motor_absent_raw,
    input wire logic pwm_cycle_start,
    input wire logic high_side_mod,
    input wire logic [15:0] phase_current_ma,
    input wire logic [7:0] sense_amp_gain,
    input wire fcl_pkg::fcl_gate_e gate_state,
    input wire logic fault_output_low,
    input wire logic absent_motor,
    input wire logic irq
);
    import fcl_pkg::*;
    // ----
    // shadow of the config word
    // ----
    logic [31:0] cfg_reg;
    int raw_cnt;
    wire cfg_wr = psel && penable && pready && pwrite && paddr == ADDR_CFG;
    wire [3:0] pcl = cfg_reg[26:23];
    // lock reactions below 8 may drive the gate too, so fault checks skip them
    wire lck_quiet = cfg_reg[18:15] >= 4'h8;
    wire mapped = paddr inside {ADDR_CFG, ADDR_IRQ_STATUS, ADDR_IRQ_ENABLE, ADDR_IRQ_CLEAR,
        ADDR_STATE, ADDR_CTRL};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_reg <= 32'h0;
            raw_cnt <= 0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (cfg_wr && pstrb[i]) begin
                    cfg_reg[8*i+:8] <= pwdata[8*i+:8];
                end
            end
            raw_cnt <= motor_absent_raw ? raw_cnt + 1 : 0;
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_first: assert property ($rose(penable) && psel |-> pready)
        else $error("pready missing in first access cycle");
    a_ready_single: assert property (pready |=> !pready)
        else $error("pready held too long");
    a_err_unmapped: assert property (psel && penable && pready |-> pslverr == !mapped)
        else $error("pslverr wrong for address");
    a_cfg_readback: assert property (
        psel && penable && pready && !pwrite && paddr == ADDR_CFG |-> prdata == cfg_reg)
        else $error("config readback differs");
    a_fault_quiet: assert property (
        gate_state == GATE_RECIRC && cfg_reg[23] && pcl < 4'h6 && lck_quiet |-> fault_output_low)
        else $error("fault asserted in quiet mode");
    a_fault_active: assert property (
        gate_state == GATE_RECIRC && !cfg_reg[23] && pcl < 4'h6 && lck_quiet |-> !fault_output_low)
        else $error("fault missing in active mode");
    a_no_action: assert property (
        (pcl >= 4'h6 && lck_quiet) [*2] |-> gate_state == GATE_DRIVE)
        else $error("gate acted in report or disabled mode");
    a_hit_recirc: assert property (
        $rose(phase_over_limit) && pcl < 4'h2 && gate_state == GATE_DRIVE
        |-> ##[2:6] gate_state == GATE_RECIRC)
        else $error("limit hit not answered");
    a_absent_drop: assert property (!motor_absent_raw [*5] |-> !absent_motor)
        else $error("absent flag stuck");
    a_absent_filter: assert property (
        $rose(absent_motor) && cfg_reg[29:27] == 3'h1 |-> raw_cnt >= 9 * MS_CYCLES)
        else $error("absent flag before filter time");
    cover property (gate_state == GATE_RECIRC);
    cover property ($rose(absent_motor));
    cover property (pready && pslverr);
endmodule

bind fcl_fault_cfg fcl_fault_cfg_monitor #(.MS_CYCLES(MS_CYCLES)) mon_u (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .phase_over_limit(phase_over_limit), .motor_absent_raw(motor_absent_raw),
    .pwm_cycle_start(pwm_cycle_start), .high_side_mod(high_side_mod),
    .phase_current_ma(phase_current_ma), .sense_amp_gain(sense_amp_gain),
    .gate_state(gate_state), .fault_output_low(fault_output_low),
    .absent_motor(absent_motor), .irq(irq));

// ### bench/test_fcl_fault_cfg.sv
`timescale 1ns/1ps
module test_fcl_fault_cfg;
    import fcl_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hf;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic phase_over_limit = 1'b0;
    logic motor_absent_raw = 1'b0;
    logic pwm_cycle_start = 1'b0;
    logic high_side_mod = 1'b0;
    logic [15:0] phase_current_ma = 16'h0;
    logic [7:0] sense_amp_gain = 8'h32;
    fcl_gate_e gate_state;
    logic fault_output_low;
    logic absent_motor;
    logic irq;
    logic irq_en = 1'b1;
    int failures = 0;
    int samples_checked = 0;
    logic [32:0] rd_q[$];

    always #12.5 pclk = ~pclk;

    // short millisecond keeps the filter waits to about a hundred cycles
    fcl_fault_cfg #(.MS_CYCLES(10)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .phase_over_limit(phase_over_limit), .motor_absent_raw(motor_absent_raw),
        .pwm_cycle_start(pwm_cycle_start), .high_side_mod(high_side_mod),
        .phase_current_ma(phase_current_ma), .sense_amp_gain(sense_amp_gain),
        .gate_state(gate_state), .fault_output_low(fault_output_low),
        .absent_motor(absent_motor), .irq(irq));

    // ----
    // helpers
    // ----
    task automatic conclude();
        if (rd_q.size() != 0) failures++;
        $display("checked %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic check_read(input logic [32:0] got, input logic [32:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: read %h expected %h", $time, got, exp);
        end
    endtask
    task automatic check_pins(input logic [5:0] exp);
        samples_checked++;
        if ({gate_state, fault_output_low, absent_motor, irq} !== exp) begin
            failures++;
            $display("Error at %0t: pins %b expected %b", $time,
                {gate_state, fault_output_low, absent_motor, irq}, exp);
        end
    endtask
    function automatic logic [31:0] cfgw(input logic [2:0] a, input logic [3:0] p,
        input logic [3:0] t, input logic [3:0] l, input logic [2:0] r);
        return {2'b00, a, p, t, l, 4'h0, r, 8'h00};
    endfunction
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        input logic [3:0] s);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 4'hf);
    endtask
    task automatic rd(input logic [11:0] a, input logic [32:0] e);
        rd_q.push_back(e);
        apb(1'b0, a, 32'h0, 4'hf);
    endtask
    task automatic pwm_pulse();
        @(posedge pclk);
        pwm_cycle_start <= 1'b1;
        @(posedge pclk);
        pwm_cycle_start <= 1'b0;
        cyc(3);
    endtask
    // one limit hit under reaction m, with pin held then dropped
    task automatic pcl_case(input logic [3:0] m, input logic hs);
        logic ev;
        logic act;
        logic nf;
        logic [2:0] g;
        ev = m < 4'h7 && !(m[3:1] == 3'h1 && !hs);
        act = ev && m != 4'h6;
        nf = act && !m[0];
        g = act ? GATE_RECIRC : GATE_DRIVE;
        high_side_mod <= hs;
        wr(ADDR_CFG, cfgw(3'h0, m, 4'h1, 4'h9, 3'h2));
        @(posedge pclk);
        phase_over_limit <= 1'b1;
        cyc(6);
        check_pins({g, !nf, 1'b0, ev & irq_en});
        phase_over_limit <= 1'b0;
        cyc(6);
        if (m[3:1] == 3'h1) begin
            check_pins({GATE_DRIVE, 2'b10, ev & irq_en});
        end else begin
            check_pins({g, !nf, 1'b0, ev & irq_en});
            pwm_pulse();
            if (m[3:1] == 3'h2) begin
                check_pins({g, !nf, 1'b0, ev & irq_en});
                pwm_pulse();
            end
            check_pins({GATE_DRIVE, 2'b10, ev & irq_en});
        end
        rd(ADDR_IRQ_STATUS, {32'h0, ev});
        wr(ADDR_IRQ_CLEAR, 32'h7);
    endtask

    // ----
    // monitor: read data against the oldest note
    // ----
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            check_read({pslverr, prdata}, rd_q.pop_front());
        end
    end

    initial begin
        #(25 * 20000);
        failures++;
        conclude();
    end

    initial begin
        logic [31:0] d;
        logic [3:0] c;
        void'($urandom(32'h9eb4));
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        check_pins({GATE_DRIVE, 3'b100});
        rd(ADDR_CFG, 33'h0);
        rd(12'hffc, {1'b1, 32'h0});
        d = $urandom;
        wr(ADDR_CFG, d);
        rd(ADDR_CFG, {1'b0, d});
        apb(1'b1, ADDR_CFG, 32'hffffffff, 4'h2);
        rd(ADDR_CFG, {1'b0, d | 32'h0000ff00});
        wr(ADDR_IRQ_ENABLE, 32'h1);
        for (int m = 0; m < 16; m++) begin
            pcl_case(4'(m), 1'b1);
        end
        pcl_case(4'h2, 1'b0);
        pcl_case(4'h3, 1'b0);
        // masked source still latches its status bit
        wr(ADDR_IRQ_ENABLE, 32'h0);
        irq_en = 1'b0;
        pcl_case(4'h6, 1'b1);
        c = 4'($urandom_range(15, 1));
        wr(ADDR_CFG, cfgw(3'h0, 4'h7, c, 4'h8, 3'h0));
        phase_current_ma <= 16'(c * 2000 - 1);
        cyc(6);
        rd(ADDR_IRQ_STATUS, 33'h0);
        phase_current_ma <= 16'(c * 2000);
        cyc(6);
        rd(ADDR_IRQ_STATUS, 33'h2);
        wr(ADDR_IRQ_CLEAR, 32'h7);
        wr(ADDR_CFG, cfgw(3'h0, 4'h7, c, 4'h0, 3'h0));
        cyc(4);
        check_pins({GATE_TRISTATE, 3'b000});
        phase_current_ma <= 16'h0;
        wr(ADDR_CTRL, 32'h1);
        cyc(3);
        check_pins({GATE_DRIVE, 3'b100});
        wr(ADDR_IRQ_CLEAR, 32'h7);
        wr(ADDR_CFG, cfgw(3'h0, 4'h7, 4'h0, 4'h8, 3'h0));
        phase_current_ma <= 16'hffff;
        cyc(6);
        rd(ADDR_IRQ_STATUS, 33'h0);
        phase_current_ma <= 16'h0;
        wr(ADDR_CFG, cfgw(3'h1, 4'h7, 4'h0, 4'h9, 3'h0));
        motor_absent_raw <= 1'b1;
        cyc(85);
        check_pins({GATE_DRIVE, 3'b100});
        cyc(30);
        check_pins({GATE_DRIVE, 3'b110});
        rd(ADDR_IRQ_STATUS, 33'h4);
        motor_absent_raw <= 1'b0;
        cyc(5);
        check_pins({GATE_DRIVE, 3'b100});
        cyc(4);
        conclude();
    end
endmodule
